// ---- src/pbw_config.sv ----
// Clock multiplier setup and bus wait configuration registers on AHB-Lite.
// Assumes hready from the single slave drives the bus and word-only accesses.
// How it works
// - The setup register sits at F8h and resets to 050Fh.
// - Setup bits 11 to 10 select divisor M of 1, 2, 3 or 4.
// - Setup bits 9 to 8 select divisor R of 1, 2, 4 or 8.
// - Setup bits 4 to 0 give multiplier N as the code plus one.
// - The clock equals the reference frequency times N over M times R.
// - A read-only release level register at F4h returns a fixed value.
// - The upper select control register sits at A0h and resets to F033h.
// - Bit 3 with bits 1-0 select 0, 1, 2, 3, 5, 7, 9 or 15 wait states.
// - The pin select control register sits at F0h and resets to 0000h.
// - Latch strobe wait bit 3 set adds one first bus state for five states.
`timescale 1ns/10ps
`default_nettype none
module pbw_config
  import pbw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [2:0] pre_divide_m,
  output logic [3:0] post_divide_r,
  output logic [5:0] feedback_multiply_n,
  output logic clock_locked,
  output logic [3:0] upper_select_waits,
  output logic [2:0] bus_cycle_states
);
  import pbw_pkg::*;

  // ****************************************************************
  // Bus address phase capture
  // ****************************************************************
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_valid;
  logic [15:0] upper_select_control_q;
  logic [15:0] pin_select_control_q;
  logic [15:0] clock_multiplier_setup_q;
  logic [15:0] active_setup_q;
  logic [15:0] rd_data;
  pbw_lock_state_e lock_state_q;
  logic lock_start;
  logic lock_done;
  logic [1:0] pre_code;
  logic [1:0] post_code;
  logic [4:0] fb_code;
  logic [2:0] wait_code;

  assign rd_valid = hsel && hready && htrans[1] && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_select_control_q <= PBW_UPPER_SELECT_CONTROL_RST;
    end else if (wr_pend_q && wr_addr_q == PBW_UPPER_SELECT_CONTROL_ADDR) begin
      upper_select_control_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_select_control_q <= PBW_PIN_SELECT_CONTROL_RST;
    end else if (wr_pend_q && wr_addr_q == PBW_PIN_SELECT_CONTROL_ADDR) begin
      pin_select_control_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_multiplier_setup_q <= PBW_CLOCK_MULTIPLIER_SETUP_RST;
    end else if (wr_pend_q && wr_addr_q == PBW_CLOCK_MULTIPLIER_SETUP_ADDR) begin
      clock_multiplier_setup_q <= hwdata[15:0] & PBW_SETUP_WRITE_MASK;
    end
  end

  assign lock_start = wr_pend_q && wr_addr_q == PBW_CLOCK_MULTIPLIER_SETUP_ADDR;

  // ****************************************************************
  // Lock sequencing
  // ****************************************************************
  pbw_lock_timer #(
    .CYCLES(PBW_LOCK_CYCLES)
  ) u_lock_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(lock_start),
    .done(lock_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_state_q <= PBW_RUN;
    end else begin
      unique case (lock_state_q)
        PBW_RUN: begin
          if (lock_start) begin
            lock_state_q <= PBW_WAIT_LOCK;
          end
        end
        PBW_WAIT_LOCK: begin
          if (lock_start) begin
            lock_state_q <= PBW_WAIT_LOCK;
          end else if (lock_done) begin
            lock_state_q <= PBW_SWITCH;
          end
        end
        PBW_SWITCH: begin
          lock_state_q <= lock_start ? PBW_WAIT_LOCK : PBW_RUN;
        end
      endcase
    end
  end

  // The active divider set changes in a single edge, so no partial mix shows.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_setup_q <= PBW_CLOCK_MULTIPLIER_SETUP_RST;
    end else if (lock_state_q == PBW_SWITCH) begin
      active_setup_q <= clock_multiplier_setup_q;
    end
  end

  assign clock_locked = (lock_state_q == PBW_RUN);

  // ****************************************************************
  // Divider decode
  // ****************************************************************
  assign pre_code = active_setup_q[PBW_PRE_DIVIDE_LSB +: 2];
  assign post_code = active_setup_q[PBW_POST_DIVIDE_LSB +: 2];
  assign fb_code = active_setup_q[PBW_FEEDBACK_LSB +: 5];

  // Output clock = reference * N / (M * R); software keeps it within limits.
  always_comb begin
    pre_divide_m = {1'b0, pre_code} + 3'd1;
    post_divide_r = 4'(4'd1 << post_code);
    feedback_multiply_n = {1'b0, fb_code} + 6'd1;
  end

  // ****************************************************************
  // Bus timing decode
  // ****************************************************************
  assign wait_code = {upper_select_control_q[PBW_WAIT_EXTEND_BIT],
                      upper_select_control_q[PBW_WAIT_COUNT_LSB +: 2]};

  always_comb begin
    unique case (wait_code)
      3'h0: upper_select_waits = 4'h0;
      3'h1: upper_select_waits = 4'h1;
      3'h2: upper_select_waits = 4'h2;
      3'h3: upper_select_waits = 4'h3;
      3'h4: upper_select_waits = 4'h5;
      3'h5: upper_select_waits = 4'h7;
      3'h6: upper_select_waits = 4'h9;
      3'h7: upper_select_waits = 4'hF;
    endcase
  end

  assign bus_cycle_states = 3'(PBW_BASE_BUS_STATES)
    + {2'b00, pin_select_control_q[PBW_LATCH_STROBE_WAIT_BIT]};

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    unique case (haddr)
      PBW_UPPER_SELECT_CONTROL_ADDR: rd_data = upper_select_control_q;
      PBW_PIN_SELECT_CONTROL_ADDR: rd_data = pin_select_control_q;
      PBW_RELEASE_LEVEL_ADDR: rd_data = PBW_RELEASE_LEVEL_VALUE;
      PBW_CLOCK_MULTIPLIER_SETUP_ADDR: rd_data = clock_multiplier_setup_q;
      PBW_LOCK_STATUS_ADDR: rd_data = {15'h0000, clock_locked};
      default: rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_valid) begin
      hrdata <= {16'h0000, rd_data};
    end
  end

endmodule // pbw_config
`default_nettype wire

// ---- src/pbw_lock_timer.sv ----
// Lock settle timer for the clock multiplier.
// Assumes a single clock domain; start is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module pbw_lock_timer #(
  parameter int CYCLES = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  output logic done
);

  logic [15:0] count_q;
  logic busy_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= 16'h0000;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_q <= 16'(CYCLES - 1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (count_q == 16'h0000) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - 16'h0001;
        end
      end
    end
  end

endmodule // pbw_lock_timer
`default_nettype wire

// ---- src/pbw_pkg.sv ----
// Package for the clock multiplier setup and bus wait configuration block.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package pbw_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] PBW_UPPER_SELECT_CONTROL_ADDR = 8'hA0;
  localparam logic [7:0] PBW_PIN_SELECT_CONTROL_ADDR = 8'hF0;
  localparam logic [7:0] PBW_RELEASE_LEVEL_ADDR = 8'hF4;
  localparam logic [7:0] PBW_CLOCK_MULTIPLIER_SETUP_ADDR = 8'hF8;
  localparam logic [7:0] PBW_LOCK_STATUS_ADDR = 8'hFC;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [15:0] PBW_UPPER_SELECT_CONTROL_RST = 16'hF033;
  localparam logic [15:0] PBW_PIN_SELECT_CONTROL_RST = 16'h0000;
  localparam logic [15:0] PBW_CLOCK_MULTIPLIER_SETUP_RST = 16'h050F;
  localparam logic [15:0] PBW_SETUP_WRITE_MASK = 16'h0F1F;
  // Arbitrary neutral identification value.
  localparam logic [15:0] PBW_RELEASE_LEVEL_VALUE = 16'h1234;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PBW_PRE_DIVIDE_LSB = 10;
  localparam int PBW_POST_DIVIDE_LSB = 8;
  localparam int PBW_FEEDBACK_LSB = 0;
  localparam int PBW_WAIT_EXTEND_BIT = 3;
  localparam int PBW_WAIT_COUNT_LSB = 0;
  localparam int PBW_LATCH_STROBE_WAIT_BIT = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PBW_CLK_MHZ = 40;
  localparam int PBW_LOCK_TIME_NS = 1000;
  localparam int PBW_LOCK_CYCLES = (PBW_LOCK_TIME_NS * PBW_CLK_MHZ + 999) / 1000;
  localparam int PBW_BASE_BUS_STATES = 4;

  typedef enum logic [1:0] {
    PBW_RUN,
    PBW_WAIT_LOCK,
    PBW_SWITCH
  } pbw_lock_state_e;

endpackage : pbw_pkg

// ---- test/pbw_config_chk.sv ----
// Checker of the configuration block's outputs.
// Assumes binding to pbw_config, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module pbw_config_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] hrdata,
  input wire logic [2:0] pre_divide_m,
  input wire logic [3:0] post_divide_r,
  input wire logic [5:0] feedback_multiply_n,
  input wire logic clock_locked,
  input wire logic [3:0] upper_select_waits,
  input wire logic [2:0] bus_cycle_states
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pre_range: assert property (pre_divide_m inside {[1:4]})
    else $error("pre divisor out of range");
  a_post_pow: assert property (post_divide_r inside {1, 2, 4, 8})
    else $error("post divisor out of range");
  a_fb_range: assert property (feedback_multiply_n inside {[1:32]})
    else $error("multiplier out of range");
  a_wait_set: assert property (upper_select_waits inside {0, 1, 2, 3, 5, 7, 9, 15})
    else $error("wait count not in set");
  a_state_count: assert property (bus_cycle_states inside {4, 5})
    else $error("bus state count wrong");
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_hold_unlocked: assert property (!clock_locked |->
    $stable({pre_divide_m, post_divide_r, feedback_multiply_n}))
    else $error("divider moved before lock");
  a_lock_span: assert property ($fell(clock_locked) |-> !clock_locked [*8])
    else $error("lock wait too short");
endmodule // pbw_config_chk
bind pbw_config pbw_config_chk u_pbw_config_chk (.hclk(hclk), .hresetn(hresetn),
  .hrdata(hrdata), .pre_divide_m(pre_divide_m), .post_divide_r(post_divide_r),
  .feedback_multiply_n(feedback_multiply_n), .clock_locked(clock_locked),
  .upper_select_waits(upper_select_waits), .bus_cycle_states(bus_cycle_states));
`default_nettype wire

// ---- test/pbw_config_test.sv ----
// Self-checking testbench of the configuration block.
// Assumes an AHB-Lite slave whose hreadyout feeds hready.
`timescale 1ns/10ps
`default_nettype none
module pbw_config_test;
  import pbw_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, clock_locked;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, pre_divide_m, bus_cycle_states;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic [3:0] post_divide_r, upper_select_waits;
  logic [5:0] feedback_multiply_n;
  int bad_count = 0, num_checks = 0;
  always #12.5 hclk = ~hclk;
  pbw_config u_pbw_config (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pre_divide_m(pre_divide_m),
    .post_divide_r(post_divide_r), .feedback_multiply_n(feedback_multiply_n),
    .clock_locked(clock_locked), .upper_select_waits(upper_select_waits),
    .bus_cycle_states(bus_cycle_states));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Waits for a ready edge, or for the lock flag when lk is set.
  task automatic wt(input logic lk);
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge hclk);
      #1;
      if ((lk ? clock_locked : hreadyout) === 1'b1) break;
    end
    if (i == 100) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt(1'b0);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wt(1'b0);
    q = hrdata;
  endtask
  // **********
  // Scenarios
  // **********
  task automatic t_reset;
    bus(0, 8'hA0, 0); chk("upper", 16'hF033, q);
    bus(0, 8'hF0, 0); chk("pin", 0, q);
    bus(0, 8'hF8, 0); chk("setup", 16'h050F, q);
    chk("m", 2, pre_divide_m);
    chk("r", 2, post_divide_r);
    chk("n", 16, feedback_multiply_n);
    chk("waits", 3, upper_select_waits);
    chk("states", 4, bus_cycle_states);
    chk("hresp", 0, hresp);
    chk("hreadyout", 1, hreadyout);
    $display("t_reset done");
  endtask
  task automatic t_setup;
    int i;
    logic [15:0] d;
    logic [2:0] em;
    em = 2;
    for (i = 0; i < 4; i++) begin
      d = 16'hF0E0 | (i << 10) | (i << 8) | (i * 10);
      bus(1, 8'hF8, d);
      wt(1'b0);
      chk("unlocked", 0, clock_locked);
      chk("m_old", em, pre_divide_m);
      bus(0, 8'hFC, 0); chk("lock_reg", 0, q);
      wt(1'b1);
      bus(0, 8'hFC, 0); chk("lock_reg", 1, q);
      em = i + 1;
      chk("m", em, pre_divide_m);
      chk("r", 1 << i, post_divide_r);
      chk("n", i * 10 + 1, feedback_multiply_n);
      chk("ratio", (i * 10 + 1) * 8 / (em * (1 << i)), 8 * feedback_multiply_n /
        (pre_divide_m * post_divide_r));
      bus(0, 8'hF8, 0); chk("setup", d & 16'h0F1F, q);
    end
    $display("t_setup done");
  endtask
  task automatic t_waits;
    int c;
    logic [15:0] d;
    int w [8] = '{0, 1, 2, 3, 5, 7, 9, 15};
    for (c = 0; c < 8; c++) begin
      d = 16'hF030 | ((c & 4) << 1) | (c & 3);
      bus(1, 8'hA0, d); chk("waits", w[c], upper_select_waits);
      bus(0, 8'hA0, 0); chk("upper", d, q);
    end
    $display("t_waits done");
  endtask
  task automatic t_pin;
    bus(1, 8'hF0, 16'h0008); chk("states", 5, bus_cycle_states);
    bus(1, 8'hF0, 16'hFFF7); chk("states", 4, bus_cycle_states);
    bus(0, 8'hF0, 0); chk("pin", 16'hFFF7, q);
    bus(1, 8'hF4, 16'hFFFF);
    bus(0, 8'hF4, 0); chk("release", PBW_RELEASE_LEVEL_VALUE, q);
    bus(1, 8'h10, 16'hFFFF);
    bus(0, 8'h10, 0); chk("unmapped", 0, q);
    $display("t_pin done");
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_setup();
    t_waits();
    t_pin();
    wrap_up();
  end
endmodule // pbw_config_test
`default_nettype wire
